// ### hw/gtt_pkg.sv
// register map, field layout and step constants of the general timer block
// assumes a 32-bit apb slave with one register per aligned word
package gtt_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int        ADDR_W          = 10;
    localparam logic [7:0] IDX_CTRL       = 8'h12;
    localparam logic [7:0] IDX_GPT_HI     = 8'h13;
    localparam logic [7:0] IDX_GPT_LO     = 8'h14;
    localparam logic [7:0] IDX_STATUS     = 8'h1F;

    // ------------------------------------------------------------------
    // timer_and_payment_control fields
    // ------------------------------------------------------------------
    localparam int        CTRL_TRIG_HI    = 7;
    localparam int        CTRL_TRIG_LO    = 5;
    localparam int        CTRL_MRT_STEP   = 3;
    localparam int        CTRL_NRT_NFC    = 2;
    localparam int        CTRL_NRT_PAY    = 1;
    localparam int        CTRL_NRT_STEP   = 0;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] CTRL_WMASK     = 8'hEF;
    localparam logic [15:0] GPT_RST       = 16'h0000;

    // trigger source codes
    localparam logic [2:0] TRIG_NONE      = 3'h0;
    localparam logic [2:0] TRIG_RX_END    = 3'h1;
    localparam logic [2:0] TRIG_RX_START  = 3'h2;
    localparam logic [2:0] TRIG_TX_END    = 3'h3;

    // status fields
    localparam int        ST_GPT_RUN      = 0;
    localparam int        ST_NRT_RUN      = 1;
    localparam int        ST_MASK_RUN     = 2;

    // ------------------------------------------------------------------
    // steps in carrier clock periods
    // ------------------------------------------------------------------
    localparam int        DIV_W           = 13;
    localparam logic [12:0] GPT_STEP_CAR  = 13'h0008;
    localparam logic [12:0] MRT_STEP_SHORT = 13'h0040;
    localparam logic [12:0] MRT_STEP_LONG = 13'h0200;
    localparam logic [12:0] NRT_STEP_SHORT = 13'h0040;
    localparam logic [12:0] NRT_STEP_LONG = 13'h1000;

    // system clock period and general timer step, in ns
    localparam int        CLK_PERIOD_NS   = 25;
    localparam int        GPT_STEP_NS     = 590;

endpackage

// ### hw/gtt_prescaler.sv
// carrier tick divider producing one step pulse every div_i carrier ticks
// assumes carrier_tick_i is a one-cycle pulse on clk_sys_i
`timescale 1ns/1ps
module gtt_prescaler #(
    parameter int DW = 13
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    // control
    input  wire logic          clear_i,
    input  wire logic          carrier_tick_i,
    input  wire logic [DW-1:0] div_i,
    // step out
    output logic               step_o
);
    logic [DW-1:0] cnt_reg;

    // clear realigns so the first step after a start is a full one
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || clear_i) begin
            cnt_reg <= '0;
            step_o  <= 1'b0;
        end else if (carrier_tick_i) begin
            if (cnt_reg >= div_i - DW'(1)) begin
                cnt_reg <= '0;
                step_o  <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + DW'(1);
                step_o  <= 1'b0;
            end
        end else begin
            step_o <= 1'b0;
        end
    end
endmodule

// ### hw/gtt_step_counter.sv
// reloadable down counter, one decrement per step pulse
// assumes start_i, stop_i and step_i are one-cycle pulses on clk_sys_i
`timescale 1ns/1ps
module gtt_step_counter #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    // control
    input  wire logic         start_i,
    input  wire logic         stop_i,
    input  wire logic [W-1:0] load_i,
    input  wire logic         step_i,
    // state
    output logic              running_o,
    output logic              expire_o,
    output logic [W-1:0]      count_o
);
    // a start always reloads, even while running
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            running_o <= 1'b0;
            expire_o  <= 1'b0;
            count_o   <= '0;
        end else if (start_i) begin
            running_o <= (load_i != '0);
            expire_o  <= 1'b0;
            count_o   <= load_i;
        end else if (stop_i) begin
            running_o <= 1'b0;
            expire_o  <= 1'b0;
        end else if (running_o && step_i) begin
            count_o   <= count_o - W'(1);
            running_o <= (count_o != W'(1));
            expire_o  <= (count_o == W'(1));
        end else begin
            expire_o <= 1'b0;
        end
    end
endmodule

// ### hw/gtt_timer_ctrl.sv
// general timer with trigger select and receive-mask / no-response timing
// assumes apb master on clk_sys_i, event inputs from logic on the same clock,
// carrier clock arriving as an asynchronous pin
//
// Behaviour
// - direct command always starts general timer
// - trigger select field bits 7..5, reset zero
// - code 000 adds no hardware trigger
// - code 001 also starts at reception end
// - code 010 also starts at reception start
// - code 011 also starts at transmission end
// - peer mode, code 011: expiry drops field
// - peer mode, code 011 enables no-response start
// - bit 3 picks mask step 64/512
// - bit 2 picks no-response start event
// - bit 1 selects payment no-response mode
// - bit 0 picks no-response step 64/4096
// - 16-bit timeout, high then low register
// - one timeout count is 8 carrier periods
// - timeout spans one step to full count
// - no-response expiry without reply raises event
// - receiver output ignored during mask interval
// - general expiry event; its interrupt suppressible by mask
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module gtt_timer_ctrl (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [9:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // carrier clock pin
    input  wire logic        carrier_clock_i,
    // framing events and commands
    input  wire logic        cmd_start_gpt_i,
    input  wire logic        cmd_start_nrt_i,
    input  wire logic        rx_start_i,
    input  wire logic        rx_end_i,
    input  wire logic        tx_end_i,
    input  wire logic        peer_field_on_i,
    input  wire logic        active_peer_mode_i,
    input  wire logic        gpe_mask_i,
    // timer values held elsewhere
    input  wire logic [7:0]  mrt_value_i,
    input  wire logic [15:0] nrt_value_i,
    // receiver path
    input  wire logic        rx_data_i,
    output logic             rx_data_o,
    // results
    output logic             rx_mask_o,
    output logic             gpe_event_o,
    output logic             gpe_irq_o,
    output logic             nre_event_o,
    output logic             field_off_o,
    output logic             nrt_payment_mode_o
);
    // ------------------------------------------------------------------
    // registers and apb
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_reg;
    logic [15:0] gpt_value_reg;
    logic [7:0]  status_next;
    logic [31:0] rdata_next;
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic [7:0]  idx;
    logic [2:0]  trig;

    assign idx   = paddr_i[9:2];
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign trig  = ctrl_reg[gtt_pkg::CTRL_TRIG_HI:gtt_pkg::CTRL_TRIG_LO];
    assign mapped = (idx == gtt_pkg::IDX_CTRL) || (idx == gtt_pkg::IDX_GPT_HI)
                 || (idx == gtt_pkg::IDX_GPT_LO) || (idx == gtt_pkg::IDX_STATUS);

    // control register; reserved bit 4 never stores
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= gtt_pkg::CTRL_RST;
        end else if (wr_en && idx == gtt_pkg::IDX_CTRL) begin
            ctrl_reg <= pwdata_i[7:0] & gtt_pkg::CTRL_WMASK;
        end
    end

    // timeout halves; a write does not disturb a running count
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gpt_value_reg <= gtt_pkg::GPT_RST;
        end else if (wr_en && idx == gtt_pkg::IDX_GPT_HI) begin
            gpt_value_reg[15:8] <= pwdata_i[7:0];
        end else if (wr_en && idx == gtt_pkg::IDX_GPT_LO) begin
            gpt_value_reg[7:0] <= pwdata_i[7:0];
        end
    end

    logic gpt_running;
    logic nrt_running;
    logic mrt_running;

    always_comb begin
        status_next = '0;
        status_next[gtt_pkg::ST_GPT_RUN]  = gpt_running;
        status_next[gtt_pkg::ST_NRT_RUN]  = nrt_running;
        status_next[gtt_pkg::ST_MASK_RUN] = mrt_running;
        case (idx)
            gtt_pkg::IDX_CTRL:   rdata_next = {24'h000000, ctrl_reg};
            gtt_pkg::IDX_GPT_HI: rdata_next = {24'h000000, gpt_value_reg[15:8]};
            gtt_pkg::IDX_GPT_LO: rdata_next = {24'h000000, gpt_value_reg[7:0]};
            gtt_pkg::IDX_STATUS: rdata_next = {24'h000000, status_next};
            default:             rdata_next = 32'h00000000;
        endcase
    end

    // answer is prepared in the setup cycle, so no wait states
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else if (setup) begin
            pready_o  <= 1'b1;
            pslverr_o <= !mapped;
            prdata_o  <= pwrite_i ? 32'h00000000 : rdata_next;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end
    end

    // ------------------------------------------------------------------
    // carrier clock synchroniser
    // ------------------------------------------------------------------
    logic car_meta_reg;
    logic car_sync_reg;
    logic car_last_reg;
    logic car_tick;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            car_meta_reg <= 1'b0;
            car_sync_reg <= 1'b0;
            car_last_reg <= 1'b0;
        end else begin
            car_meta_reg <= carrier_clock_i;
            car_sync_reg <= car_meta_reg;
            car_last_reg <= car_sync_reg;
        end
    end
    // rising edges only; carrier must stay below half the system rate
    assign car_tick = car_sync_reg && !car_last_reg;

    // ------------------------------------------------------------------
    // general purpose timer
    // ------------------------------------------------------------------
    logic        gpt_hw_start;
    logic        gpt_start;
    logic        gpt_step;
    logic        gpt_expire;
    logic [15:0] gpt_count;
    logic        peer_txend_mode;

    assign peer_txend_mode = active_peer_mode_i && (trig == gtt_pkg::TRIG_TX_END);

    always_comb begin
        case (trig)
            gtt_pkg::TRIG_NONE:     gpt_hw_start = 1'b0;
            gtt_pkg::TRIG_RX_END:   gpt_hw_start = rx_end_i;
            gtt_pkg::TRIG_RX_START: gpt_hw_start = rx_start_i;
            gtt_pkg::TRIG_TX_END:   gpt_hw_start = tx_end_i;
            default:                gpt_hw_start = 1'b0;
        endcase
    end
    assign gpt_start = cmd_start_gpt_i || gpt_hw_start;

    gtt_prescaler #(
        .DW (gtt_pkg::DIV_W)
    ) u_gpt_div (
        .clk_sys_i      (clk_sys_i),
        .rst_n_i        (rst_n_i),
        .clear_i        (gpt_start),
        .carrier_tick_i (car_tick),
        .div_i          (gtt_pkg::GPT_STEP_CAR),
        .step_o         (gpt_step)
    );

    // restart reloads through the counter's start path
    gtt_step_counter #(
        .W (16)
    ) u_gpt (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (gpt_start),
        .stop_i    (1'b0),
        .load_i    (gpt_value_reg),
        .step_i    (gpt_step),
        .running_o (gpt_running),
        .expire_o  (gpt_expire),
        .count_o   (gpt_count)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gpe_event_o <= 1'b0;
            gpe_irq_o   <= 1'b0;
            field_off_o <= 1'b0;
        end else begin
            gpe_event_o <= gpt_expire;
            gpe_irq_o   <= gpt_expire && !gpe_mask_i;
            field_off_o <= gpt_expire && peer_txend_mode;
        end
    end

    // ------------------------------------------------------------------
    // receive mask timer
    // ------------------------------------------------------------------
    logic [12:0] mrt_div;
    logic        mrt_step;

    assign mrt_div = ctrl_reg[gtt_pkg::CTRL_MRT_STEP] ? gtt_pkg::MRT_STEP_LONG
                                                      : gtt_pkg::MRT_STEP_SHORT;

    gtt_prescaler #(
        .DW (gtt_pkg::DIV_W)
    ) u_mrt_div (
        .clk_sys_i      (clk_sys_i),
        .rst_n_i        (rst_n_i),
        .clear_i        (tx_end_i),
        .carrier_tick_i (car_tick),
        .div_i          (mrt_div),
        .step_o         (mrt_step)
    );

    gtt_step_counter #(
        .W (8)
    ) u_mrt (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (tx_end_i),
        .stop_i    (1'b0),
        .load_i    (mrt_value_i),
        .step_i    (mrt_step),
        .running_o (mrt_running),
        .expire_o  (),
        .count_o   ()
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_mask_o <= 1'b0;
            rx_data_o <= 1'b0;
        end else begin
            rx_mask_o <= mrt_running;
            rx_data_o <= rx_data_i && !mrt_running;
        end
    end

    // ------------------------------------------------------------------
    // no-response timer
    // ------------------------------------------------------------------
    logic [12:0] nrt_div;
    logic        nrt_start;
    logic        nrt_peer_start;
    logic        nrt_step;
    logic        nrt_expire;

    assign nrt_div = ctrl_reg[gtt_pkg::CTRL_NRT_STEP] ? gtt_pkg::NRT_STEP_LONG
                                                      : gtt_pkg::NRT_STEP_SHORT;

    // own field off is the general timer expiry in peer mode
    always_comb begin
        if (ctrl_reg[gtt_pkg::CTRL_NRT_NFC]) begin
            nrt_peer_start = peer_field_on_i;
        end else begin
            nrt_peer_start = gpt_expire;
        end
    end

    // peer mode needs code 011 to arm the start; otherwise end of tx
    assign nrt_start = cmd_start_nrt_i
                    || (active_peer_mode_i ? (peer_txend_mode && nrt_peer_start)
                                           : tx_end_i);

    gtt_prescaler #(
        .DW (gtt_pkg::DIV_W)
    ) u_nrt_div (
        .clk_sys_i      (clk_sys_i),
        .rst_n_i        (rst_n_i),
        .clear_i        (nrt_start),
        .carrier_tick_i (car_tick),
        .div_i          (nrt_div),
        .step_o         (nrt_step)
    );

    // a detected reply stops the count, so no expiry follows
    gtt_step_counter #(
        .W (16)
    ) u_nrt (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (nrt_start),
        .stop_i    (rx_start_i && !nrt_start),
        .load_i    (nrt_value_i),
        .step_i    (nrt_step),
        .running_o (nrt_running),
        .expire_o  (nrt_expire),
        .count_o   ()
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            nre_event_o        <= 1'b0;
            nrt_payment_mode_o <= 1'b0;
        end else begin
            nre_event_o        <= nrt_expire;
            nrt_payment_mode_o <= ctrl_reg[gtt_pkg::CTRL_NRT_PAY];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // counts synchronised carrier ticks, not cycles,
    // so the step check holds at any legal carrier rate
    logic [15:0] since_start_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || gpt_start) begin
            since_start_reg <= '0;
        end else if (car_tick && since_start_reg != 16'hFFFF) begin
            since_start_reg <= since_start_reg + 16'h0001;
        end
    end

    property p_cmd_start;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cmd_start_gpt_i && gpt_value_reg != '0 |=> gpt_running && gpt_count == $past(gpt_value_reg);
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command did not start timer");

    property p_no_trigger;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (trig == gtt_pkg::TRIG_NONE || trig[2]) && !cmd_start_gpt_i |-> !gpt_start;
    endproperty
    a_no_trigger: assert property (p_no_trigger) else $error("spurious timer start");

    property p_rx_end;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        trig == gtt_pkg::TRIG_RX_END && rx_end_i && gpt_value_reg != '0 |=> gpt_running;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("rx end did not start timer");

    property p_rx_start;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        trig == gtt_pkg::TRIG_RX_START && rx_start_i && gpt_value_reg != '0 |=> gpt_running;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx start did not start timer");

    property p_tx_end;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        trig == gtt_pkg::TRIG_TX_END && tx_end_i && gpt_value_reg != '0 |=> gpt_running;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("tx end did not start timer");

    property p_field_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        field_off_o |-> $past(gpt_expire) && $past(peer_txend_mode);
    endproperty
    a_field_off: assert property (p_field_off) else $error("field off without cause");

    property p_gpe_irq;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        gpt_expire |=> gpe_event_o && (gpe_irq_o == !$past(gpe_mask_i));
    endproperty
    a_gpe_irq: assert property (p_gpe_irq) else $error("expiry event wrong");

    property p_min_step;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        gpt_expire |-> since_start_reg >= 16'(gtt_pkg::GPT_STEP_CAR);
    endproperty
    a_min_step: assert property (p_min_step) else $error("timer expired too early");

    property p_mask_rx;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        tx_end_i && mrt_value_i != '0 |-> ##2 !rx_data_o && rx_mask_o;
    endproperty
    a_mask_rx: assert property (p_mask_rx) else $error("receiver not masked");

    property p_nre_reply;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_start_i && !nrt_start |=> ##1 !nre_event_o;
    endproperty
    a_nre_reply: assert property (p_nre_reply) else $error("no-response after reply");

    c_gpt_expire: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) gpe_irq_o);
    c_restart:    cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                                  gpt_running && gpt_start);
    c_nre:        cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) nre_event_o);
    c_field_off:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) field_off_o);
endmodule

// ### dv/gtt_timer_ctrl_test.sv
// self-checking bench of the general timer block: registers, triggers, steps, mask
// assumes a zero-wait apb slave and a free-running carrier pin, here 5 MHz
`timescale 1ns/1ps
module general_timer_and_timeout_control_test;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, car = 0;
    logic        cg = 0, cn = 0, rxs = 0, rxe = 0, txe = 0, pfo = 0, ap = 0, gm = 0;
    logic        rdi = 0, rdy, err, rdo, msk, gev, girq, nev, foff, pay;
    logic [9:0]  pa = '0;
    logic [31:0] pwd = '0, prd, seed = 32'h0000_4160;
    logic [7:0]  mrt = '0;
    logic [15:0] nrt = '0;
    int          n_errors = 0, n_checks = 0, ncar = 0, ed, v;

    always #12.5 clk = ~clk;
    // slow carrier keeps sync latency below one carrier period
    always #100 car = ~car;
    always @(posedge car) ncar++;

    gtt_timer_ctrl DUT (
        .clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
        .carrier_clock_i(car), .cmd_start_gpt_i(cg), .cmd_start_nrt_i(cn), .rx_start_i(rxs),
        .rx_end_i(rxe), .tx_end_i(txe), .peer_field_on_i(pfo), .active_peer_mode_i(ap),
        .gpe_mask_i(gm), .mrt_value_i(mrt), .nrt_value_i(nrt), .rx_data_i(rdi),
        .rx_data_o(rdo), .rx_mask_o(msk), .gpe_event_o(gev), .gpe_irq_o(girq),
        .nre_event_o(nev), .field_off_o(foff), .nrt_payment_mode_o(pay));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // carrier edge counts may differ by one through the pin synchroniser
    task automatic span(input int got, input int n);
        cmp(32'(got >= n - 1 && got <= n + 1), 1);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] r, output logic er);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= {idx, 2'b00};
        pwd <= {24'h000000, d};
        @(posedge clk);
        pen <= 1;
        // request stands until pready is seen high at a rising edge
        do @(posedge clk); while (rdy !== 1'b1);
        r = prd;
        er = err;
        psel <= 0;
        pen <= 0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        er;
        apb(1, idx, d, r, er);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic        er;
        apb(0, idx, 8'h00, r, er);
        cmp(r, exp);
        cmp(32'(er), 32'(ee));
    endtask

    // 0 gpt cmd, 1 nrt cmd, 2 rx end, 3 rx start, 4 tx end, 5 peer field on
    task automatic pulse(input int w);
        @(posedge clk);
        case (w)
            0: cg <= 1;
            1: cn <= 1;
            2: rxe <= 1;
            3: rxs <= 1;
            4: txe <= 1;
            default: pfo <= 1;
        endcase
        @(posedge clk);
        {cg, cn, rxe, rxs, txe, pfo} <= 6'h00;
    endtask

    // carrier edges until the event pulses, -1 if it never does
    task automatic wait_ev(input int sel, input int lim, output int e);
        int c0;
        c0 = ncar;
        e = -1;
        for (int k = 0; k < lim; k++) begin
            @(negedge clk);
            if ((sel == 0 ? gev : nev) === 1'b1) begin
                e = ncar - c0;
                break;
            end
        end
    endtask

    initial begin
        #2500000;
        n_errors++;
        close_out();
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rd(gtt_pkg::IDX_CTRL, 0, 0);
        rd(gtt_pkg::IDX_GPT_HI, 0, 0);
        rd(gtt_pkg::IDX_GPT_LO, 0, 0);
        rd(8'h20, 0, 1);
        repeat (4) begin
            v = rnd();
            wr(gtt_pkg::IDX_CTRL, v[7:0]);
            rd(gtt_pkg::IDX_CTRL, 32'(v[7:0] & gtt_pkg::CTRL_WMASK), 0);
            cmp(32'(pay), 32'(v[1]));
        end
        wr(gtt_pkg::IDX_CTRL, 8'h00);
        wr(gtt_pkg::IDX_GPT_HI, 8'h01);
        wr(gtt_pkg::IDX_GPT_LO, 8'h02);
        pulse(0);
        wait_ev(0, 17000, ed);
        span(ed, 258 * 8);
        wr(gtt_pkg::IDX_GPT_HI, 8'h00);
        pulse(0);
        repeat (60) @(posedge clk);
        pulse(0);
        wait_ev(0, 300, ed);
        span(ed, 16);
        pulse(0);
        rd(gtt_pkg::IDX_STATUS, 32'h1, 0);
        repeat (200) @(posedge clk);
        rd(gtt_pkg::IDX_STATUS, 32'h0, 0);
        wr(gtt_pkg::IDX_GPT_LO, 8'h01);
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 3; k++) begin
                v = rnd();
                ap <= v[0];
                gm <= v[1];
                wr(gtt_pkg::IDX_CTRL, {3'(c), 5'h00});
                pulse(k + 2);
                wait_ev(0, 120, ed);
                cmp(32'(ed >= 0), 32'(c == k + 1));
                if (ed >= 0) begin
                    span(ed, 8);
                    cmp(32'(girq), 32'(!v[1]));
                    cmp(32'(foff), 32'(v[0] && c == 3));
                end
            end
        end
        ap <= 0;
        nrt <= 16'h0001;
        for (int s = 0; s < 2; s++) begin
            wr(gtt_pkg::IDX_CTRL, 8'(s));
            pulse(s ? 1 : 4);
            wait_ev(1, 33500, ed);
            span(ed, s ? 4096 : 64);
        end
        ap <= 1;
        for (int c = 0; c < 2; c++) begin
            wr(gtt_pkg::IDX_CTRL, c ? 8'h64 : 8'h04);
            pulse(5);
            wait_ev(1, 600, ed);
            cmp(32'(ed >= 0), 32'(c));
            if (c) span(ed, 64);
        end
        wr(gtt_pkg::IDX_CTRL, 8'h60);
        pulse(0);
        wait_ev(0, 120, ed);
        wait_ev(1, 600, ed);
        span(ed, 64);
        ap <= 0;
        nrt <= '0;
        rdi <= 1;
        mrt <= 8'h01;
        for (int s = 0; s < 2; s++) begin
            wr(gtt_pkg::IDX_CTRL, s ? 8'h08 : 8'h00);
            pulse(4);
            repeat (3) @(negedge clk);
            cmp(32'(msk), 1);
            v = ncar;
            while (msk === 1'b1) begin
                @(negedge clk);
                if (msk === 1'b1 && rdo !== 1'b0) cmp(32'(rdo), 0);
            end
            cmp(32'(rdo), 1);
            span(ncar - v, s ? 512 : 64);
        end
        close_out();
    end
endmodule
